/* include/uhx_defines.vh */
`ifndef UHX_DEFINES_VH
`define UHX_DEFINES_VH

// ****************************************
// Offsets
// ****************************************
`define UHX_OFS_RELEASE      8'h60
`define UHX_OFS_TRIM         8'h61
`define UHX_OFS_WAKE_LO      8'h62
`define UHX_OFS_WAKE_HI      8'h63
`define UHX_OFS_CAP_PTR      8'h34
`define UHX_OFS_PM_CAP       8'hdc
`define UHX_OFS_PM_NEXT      8'hdd

// ****************************************
// Values
// ****************************************
`define UHX_RELEASE_VAL      8'h20
`define UHX_TRIM_RST         8'h20
`define UHX_WAKE_RST         16'h0007
`define UHX_PM_POWER_CAPABILITY_IDENTIFIER        8'h01
`define UHX_PM_NEXT_VAL      8'h00
`define UHX_CAP_PTR_VAL      8'hdc
`define UHX_TRIM_LSB         0
`define UHX_TRIM_MSB         5

// ****************************************
// Frame timing
// ****************************************
`define UHX_FRAME_BASE       16'he860
`define UHX_FRAME_CNT_W      16
`define UHX_PERIOD_RST       16'hea60

`endif

/* src/uhx_cfg_extras.v */
`include "uhx_defines.vh"

module uhx_cfg_extras
(
  // Clock and control
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Configuration access
  input  wire [7:0]  i_cfg_addr,
  input  wire        i_cfg_wr,
  input  wire        i_cfg_rd,
  input  wire [3:0]  i_cfg_be,
  input  wire [31:0] i_cfg_wdata,
  output reg  [31:0] o_cfg_rdata,
  output reg         o_cfg_ack,
  // Frame timing
  output wire        o_sof,
  output wire [15:0] o_frame_period,
  // Stored values
  output wire [5:0]  o_frame_length_trim,
  output wire [15:0] o_port_wake_policy_mask
);

  // ****************************************
  // Fixed read values
  // ****************************************
  // Read-only bytes are constants, so no write path can ever reach them
  localparam [7:0] RELEASE_BYTE = `UHX_RELEASE_VAL;
  localparam [7:0] CAP_PTR_BYTE = `UHX_CAP_PTR_VAL;
  localparam [7:0] PM_ID_BYTE   = `UHX_PM_POWER_CAPABILITY_IDENTIFIER;
  localparam [7:0] PM_NEXT_BYTE = `UHX_PM_NEXT_VAL;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [7:0]  frame_length_trim_reg;
  reg  [7:0]  frame_length_trim_next;
  reg  [15:0] port_wake_policy_mask_reg;
  reg  [15:0] port_wake_policy_mask_next;
  reg  [31:0] rdata_next;
  wire [7:0]  dword_base;
  wire        hit_usb;
  wire        hit_cap;
  wire        hit_pm;
  wire        access;
  wire        wr_usb;
  wire [3:1]  lane_wr;
  wire [5:0]  trim_field;
  wire [31:0] usb_dword;
  wire [31:0] cap_dword;
  wire [31:0] pm_dword;

  // ****************************************
  // Address decode
  // ****************************************
  // Dword-aligned decode; byte enables pick the lanes
  // Address bits 1:0 are ignored, as a read always returns the whole dword
  assign dword_base = {i_cfg_addr[7:2], 2'b00};
  assign hit_usb    = (dword_base == `UHX_OFS_RELEASE);
  assign hit_cap    = (dword_base == `UHX_OFS_CAP_PTR);
  assign hit_pm     = (dword_base == `UHX_OFS_PM_CAP);
  assign access     = i_cfg_wr | i_cfg_rd;
  assign wr_usb     = i_cfg_wr & hit_usb;

  // ****************************************
  // Byte-lane write strobes
  // ****************************************
  // Lane 0 is the fixed release byte, so only lanes 1 to 3 get a strobe;
  // writes to the identifier dword have no strobe at all
  genvar lane;
  generate
    for (lane = 1; lane < 4; lane = lane + 1)
    begin : g_lane
      assign lane_wr[lane] = wr_usb & i_cfg_be[lane];
    end
  endgenerate

  // ****************************************
  // Writable register next values
  // ****************************************
  // Bits 7:6 of the trim byte are stored as written; only 5:0 reach the
  // frame timer, so stray high bits cannot stretch a frame
  always @*
  begin
    frame_length_trim_next = frame_length_trim_reg;
    if (lane_wr[1])
    begin
      frame_length_trim_next = i_cfg_wdata[15:8];
    end
  end

  // Wake mask: written and read back, never used inside
  always @*
  begin
    port_wake_policy_mask_next = port_wake_policy_mask_reg;
    if (lane_wr[2])
    begin
      port_wake_policy_mask_next[7:0] = i_cfg_wdata[23:16];
    end
    if (lane_wr[3])
    begin
      port_wake_policy_mask_next[15:8] = i_cfg_wdata[31:24];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  assign usb_dword = {port_wake_policy_mask_reg, frame_length_trim_reg,
                      RELEASE_BYTE};
  assign cap_dword = {24'h000000, CAP_PTR_BYTE};
  // Single identifier 01h item that ends the list; other power fields read 0
  assign pm_dword  = {16'h0000, PM_NEXT_BYTE, PM_ID_BYTE};

  // Unmapped dwords read as zero
  always @*
  begin
    rdata_next = 32'h00000000;
    case ({hit_pm, hit_cap, hit_usb})
      3'b001:
      begin
        rdata_next = usb_dword;
      end
      3'b010:
      begin
        rdata_next = cap_dword;
      end
      3'b100:
      begin
        rdata_next = pm_dword;
      end
      default:
      begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // ****************************************
  // Register stage
  // ****************************************
  // Each flop has its own process; all share the synchronous reset and the
  // enable, which freezes them together
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      frame_length_trim_reg <= `UHX_TRIM_RST;
    end
    else if (i_ce)
    begin
      frame_length_trim_reg <= frame_length_trim_next;
    end
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      port_wake_policy_mask_reg <= `UHX_WAKE_RST;
    end
    else if (i_ce)
    begin
      port_wake_policy_mask_reg <= port_wake_policy_mask_next;
    end
  end

  // Ack answers every access, including writes that change nothing,
  // so the host never waits on a read-only byte
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_cfg_ack <= 1'b0;
    end
    else if (i_ce)
    begin
      o_cfg_ack <= access;
    end
  end

  // Read data holds between reads, so a late look still sees the last answer
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_cfg_rdata <= 32'h00000000;
    end
    else if (i_ce && i_cfg_rd)
    begin
      o_cfg_rdata <= rdata_next;
    end
  end

  // ****************************************
  // Trim field
  // ****************************************
  // Only bits 5:0 set the frame length; bits 7:6 are kept for read-back
  assign trim_field = frame_length_trim_reg[`UHX_TRIM_MSB:`UHX_TRIM_LSB];

  // ****************************************
  // Outputs
  // ****************************************
  // Mask only stored; nothing inside reads it
  assign o_port_wake_policy_mask = port_wake_policy_mask_reg;
  assign o_frame_length_trim     = trim_field;

  // ****************************************
  // Frame timer
  // ****************************************
  // A new trim takes effect on the counter compare at once
  uhx_frame_timer u_timer
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_trim     (trim_field),
    .o_sof      (o_sof),
    .o_period   (o_frame_period)
  );

endmodule // uhx_cfg_extras

/* src/uhx_frame_timer.v */
`include "uhx_defines.vh"

module uhx_frame_timer
(
  // Clock and control
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Trim value
  input  wire [5:0]  i_trim,
  // Frame outputs
  output reg         o_sof,
  output reg  [15:0] o_period
);

  reg  [`UHX_FRAME_CNT_W-1:0] cnt_reg;
  wire [`UHX_FRAME_CNT_W-1:0] len_next;

  // Period is base plus 16 counts per trim step, one count per counter clock
  assign len_next = `UHX_FRAME_BASE + {6'h00, i_trim, 4'h0};

  // Counter runs 0..len-1; a new length reaches the compare at once, so a count already past it wraps on the next clock
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg  <= 16'h0000;
      o_sof    <= 1'b0;
      o_period <= `UHX_PERIOD_RST;
    end
    else if (i_ce)
    begin
      o_period <= len_next;
      if (cnt_reg >= len_next - 16'h0001)
      begin
        cnt_reg <= 16'h0000;
        o_sof   <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + 16'h0001;
        o_sof   <= 1'b0;
      end
    end
  end

endmodule // uhx_frame_timer

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_cfg_wr, i_cfg_rd, o_cfg_ack, o_sof;
  logic        i_ce = 1'b1;
  logic [7:0]  i_cfg_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata;
  logic [15:0] o_frame_period, o_port_wake_policy_mask;
  int          err_count = 0, checks_done = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  uhx_host_model host (.i_core_clk, .o_adr(i_cfg_addr), .o_wr(i_cfg_wr), .o_rd(i_cfg_rd),
    .o_be(i_cfg_be), .o_dat(i_cfg_wdata));
  uhx_cfg_extras u_uhx_cfg_extras (.*, .o_frame_length_trim());
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 4'h0, e);
    `CK("rdata", e, o_cfg_rdata)
  endtask
  task automatic conclude(input int late);
    err_count += late;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // The first frame dominates the run, so the limit sits just past it
  initial #1550000 conclude(1);
  initial
  begin
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (60000) @(negedge i_core_clk);
    `CK("sof", 1'b1, o_sof)
    rd(8'h60, 32'h0007_2020);
    rd(8'h34, 32'h0000_00dc);
    host.xfer(1'b1, 8'h60, 4'hf, 32'hbeef_3f55);
    rd(8'h63, 32'hbeef_3f20);
    `CK("mask", 16'hbeef, o_port_wake_policy_mask)
    `CK("period", 16'hec50, o_frame_period)
    host.xfer(1'b1, 8'h61, 4'h2, 32'h0);
    rd(8'h62, 32'hbeef_0020);
    `CK("period", 16'he860, o_frame_period)
    host.xfer(1'b1, 8'hdc, 4'hf, 32'hffff_ffff);
    rd(8'hdc, 32'h0000_0001);
    rd(8'h80, 32'h0);
    $display("register test done");
    // Let the last ack drop before freezing, so no stale ack survives the freeze
    @(negedge i_core_clk);
    i_ce = 1'b0;
    host.xfer(1'b1, 8'h61, 4'h2, 32'h0000_1500);
    `CK("frozen", 16'he860, o_frame_period)
    i_ce = 1'b1;
    rd(8'h60, 32'hbeef_0020);
    $display("enable test done");
    i_rst_n = 1'b0;
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    rd(8'h60, 32'h0007_2020);
    `CK("period", 16'hea60, o_frame_period)
    `CK("mask", 16'h0007, o_port_wake_policy_mask)
    $display("reset test done");
    conclude(0);
  end
endmodule // tb

/* tb/uhx_cfg_extras_asserts.sv */
module uhx_cfg_extras_asserts (
  input logic        i_core_clk,
  input logic        i_rst_n,
  input logic        i_ce,
  input logic [7:0]  i_cfg_addr,
  input logic        i_cfg_wr,
  input logic        i_cfg_rd,
  input logic [31:0] o_cfg_rdata,
  input logic        o_cfg_ack,
  input logic [15:0] o_frame_period,
  input logic [5:0]  o_frame_length_trim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);
  sequence s_rd(a); i_cfg_rd && i_cfg_addr[7:2] == a; endsequence
  property p_ack; i_cfg_rd || i_cfg_wr |=> o_cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_one; o_cfg_ack |-> $past(i_cfg_rd || i_cfg_wr); endproperty
  a_one: assert property (p_one) else $error("stray ack");
  property p_rel; s_rd(6'h18) |=> o_cfg_rdata[7:0] == 8'h20; endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_cap; s_rd(6'h0d) |=> o_cfg_rdata == 32'hdc; endproperty
  a_cap: assert property (p_cap) else $error("pointer");
  property p_pm; s_rd(6'h37) |=> o_cfg_rdata == 32'h1; endproperty
  a_pm: assert property (p_pm) else $error("pm id");
  property p_gap; s_rd(6'h20) |=> o_cfg_rdata == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped");
  property p_hold; !i_cfg_rd |=> $stable(o_cfg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_per; 1 |=> o_frame_period == 16'he860 + {$past(o_frame_length_trim), 4'h0}; endproperty
  a_per: assert property (p_per) else $error("period");
endmodule // uhx_cfg_extras_asserts
bind uhx_cfg_extras uhx_cfg_extras_asserts u_uhx_cfg_extras_asserts (.*);

/* tb/uhx_host_model.sv */
module uhx_host_model (
  input  logic        i_core_clk,
  output logic [7:0]  o_adr = 8'h0,
  output logic        o_wr = 1'b0,
  output logic        o_rd = 1'b0,
  output logic [3:0]  o_be = 4'h0,
  output logic [31:0] o_dat = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge i_core_clk);
    {o_wr, o_rd, o_adr, o_be, o_dat} = {w, !w, a, b, d};
    @(negedge i_core_clk);
    {o_wr, o_rd, o_adr, o_dat} = {2'b00, ~a, ~d};
  endtask
endmodule // uhx_host_model
